// [logic/option_latch_pkg.sv]
`default_nettype none
package option_latch_pkg;

  // --------------------------------------------------------------
  // register map (byte addresses on the 32-bit apb)
  // --------------------------------------------------------------
  localparam logic [7:0] latch_one_offset = 8'h1d;
  localparam logic [7:0] latch_two_offset = 8'h1f;
  localparam logic [7:0] latch_one_addr = 8'h74;
  localparam logic [7:0] latch_two_addr = 8'h7c;
  localparam logic [7:0] latch_reset_value = 8'h00;

  // --------------------------------------------------------------
  // field positions, first latch
  // --------------------------------------------------------------
  localparam int watchdog_rate_pos = 7;
  localparam int monitor_in_stop_pos = 6;
  localparam int lv_reset_disable_pos = 5;
  localparam int supply_mon_disable_pos = 4;
  localparam int regulator_mon_disable_pos = 3;
  localparam int short_recovery_pos = 2;
  localparam int stop_allow_pos = 1;
  localparam int watchdog_disable_pos = 0;

  // --------------------------------------------------------------
  // field positions, second latch
  // --------------------------------------------------------------
  localparam int internal_osc_stop_disable_pos = 7;
  localparam int rc_osc_stop_enable_pos = 6;
  localparam int crystal_osc_stop_enable_pos = 5;
  localparam int timebase_clock_select_high_pos = 4;
  localparam int timebase_clock_select_low_pos = 3;
  localparam int serial_port_clock_select_pos = 0;

  // --------------------------------------------------------------
  // cycle counts in internal oscillator cycles
  // --------------------------------------------------------------
  localparam logic [17:0] watchdog_short_cycles = 18'((1 << 13) - (1 << 4));
  localparam logic [17:0] watchdog_long_cycles = 18'((1 << 18) - (1 << 4));
  localparam logic [12:0] recovery_short_cycles = 13'd32;
  localparam logic [12:0] recovery_long_cycles = 13'd4096;

  // timebase clock source
  typedef enum logic [1:0] {
    tb_src_internal = 2'h0,
    tb_src_rc = 2'h1,
    tb_src_crystal = 2'h2,
    tb_src_unused = 2'h3
  } timebase_src_t;

  // decoded settings handed to the rest of the chip
  typedef struct packed {
    logic [17:0] watchdog_timeout;
    logic watchdog_enable;
    logic monitor_active_in_stop;
    logic monitor_reset_enable;
    logic supply_monitor_on;
    logic regulator_monitor_on;
    logic stop_allowed;
    logic internal_osc_run_in_stop;
    logic rc_osc_run_in_stop;
    logic crystal_osc_run_in_stop;
    timebase_src_t timebase_src;
    logic serial_port_from_bus;
  } option_settings_t;

endpackage
`default_nettype wire

// [logic/write_once_option_latches.sv]
// Functional notes
// [RQ1] each latch takes one write per reset
// [RQ2] reset clears every bit of both latches
// [RQ3] latches sit at 001D and 001F
// [RQ4] both latches readable at any time; read data only loads while clk_en is high
// [RQ5] software should program latches right after reset
// [RQ6] rate bit picks short or long watchdog timeout
// [RQ7] monitor runs in stop if enabled, circuit on
// [RQ8] reset-disable bit blocks monitor reset
// [RQ9] disable bits switch off supply/regulator monitors
// [RQ10] software sets reset-disable before unsafe stop
// [RQ11] short bit gives 32, else 4096 recovery
// [RQ12] reset-caused stop exit always uses long delay
// [RQ13] software keeps short recovery off with crystal
// [RQ14] stop-allow clear makes stop illegal opcode
// [RQ15] watchdog-disable bit turns watchdog off
// [RQ16] internal oscillator stop-disable bit
// [RQ17] rc oscillator stop-enable bit
// [RQ18] crystal oscillator stop-enable bit
// [RQ19] two-bit timebase clock source select
// [RQ20] serial port clock from bus or oscillator
// [RQ21] later writes ignored, latches eight bits
`timescale 1ns/10ps
`default_nettype none

module write_once_option_latches
  import option_latch_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // stop exit cause from the power controller
  input wire logic stop_exit_by_reset,
  // decoded settings
  output option_settings_t settings,
  output logic [12:0] stop_recovery_cycles
);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic access;
  logic hit_one;
  logic hit_two;
  logic [7:0] option_latch_one_reg;
  logic [7:0] option_latch_two_reg;
  logic written_one_reg;
  logic written_two_reg;

  // zero wait state slave: answer in the first access cycle
  assign access = psel && penable && clk_en;
  assign hit_one = (paddr == latch_one_addr); // [RQ3]
  assign hit_two = (paddr == latch_two_addr); // [RQ3]
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_one || hit_two);

  // ------------------------------------------------------------
  // first latch, write once
  // ------------------------------------------------------------
  // a write without byte lane 0 still counts as the one write,
  // so software cannot probe the latch and retry later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_latch_one_reg <= latch_reset_value; // [RQ2]
      written_one_reg <= 1'b0;
    end else if (access && pwrite && hit_one && !written_one_reg) begin // [RQ1] [RQ21]
      if (pstrb[0]) begin
        option_latch_one_reg <= pwdata[7:0];
      end
      written_one_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // second latch, write once
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_latch_two_reg <= latch_reset_value; // [RQ2]
      written_two_reg <= 1'b0;
    end else if (access && pwrite && hit_two && !written_two_reg) begin // [RQ1] [RQ21]
      if (pstrb[0]) begin
        option_latch_two_reg <= pwdata[7:0];
      end
      written_two_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read data, registered from the setup phase
  // ------------------------------------------------------------
  // ignores the written flags: reads are free whenever clk_en is high in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      if (hit_one) begin
        prdata <= {24'h00_0000, option_latch_one_reg}; // [RQ4]
      end else if (hit_two) begin
        prdata <= {24'h00_0000, option_latch_two_reg}; // [RQ4]
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // decoded settings
  // ------------------------------------------------------------
  // combinational from the latches, so the chip sees them at once
  always_comb begin
    settings.watchdog_timeout = option_latch_one_reg[watchdog_rate_pos] ?
      watchdog_short_cycles : watchdog_long_cycles; // [RQ6]
    settings.watchdog_enable = !option_latch_one_reg[watchdog_disable_pos]; // [RQ15]
    settings.supply_monitor_on = !option_latch_one_reg[supply_mon_disable_pos]; // [RQ9]
    settings.regulator_monitor_on = !option_latch_one_reg[regulator_mon_disable_pos]; // [RQ9]
    settings.monitor_active_in_stop = option_latch_one_reg[monitor_in_stop_pos] &&
      (settings.supply_monitor_on || settings.regulator_monitor_on); // [RQ7]
    settings.monitor_reset_enable = !option_latch_one_reg[lv_reset_disable_pos]; // [RQ8]
    settings.stop_allowed = option_latch_one_reg[stop_allow_pos]; // [RQ14]
    settings.internal_osc_run_in_stop =
      !option_latch_two_reg[internal_osc_stop_disable_pos]; // [RQ16]
    settings.rc_osc_run_in_stop = option_latch_two_reg[rc_osc_stop_enable_pos]; // [RQ17]
    settings.crystal_osc_run_in_stop =
      option_latch_two_reg[crystal_osc_stop_enable_pos]; // [RQ18]
    settings.timebase_src = timebase_src_t'({
      option_latch_two_reg[timebase_clock_select_high_pos],
      option_latch_two_reg[timebase_clock_select_low_pos]}); // [RQ19]
    settings.serial_port_from_bus =
      option_latch_two_reg[serial_port_clock_select_pos]; // [RQ20]
  end

  // recovery delay; a reset exit always takes the long one
  assign stop_recovery_cycles =
    (option_latch_one_reg[short_recovery_pos] && !stop_exit_by_reset) ?
    recovery_short_cycles : recovery_long_cycles; // [RQ11] [RQ12]

endmodule
`default_nettype wire

// [dv/write_once_option_latches_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module write_once_option_latches_chk
  import option_latch_pkg::*;
(
  // clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // stop exit and settings
  input wire logic stop_exit_by_reset,
  input wire option_settings_t settings,
  input wire logic [12:0] stop_recovery_cycles
);
  // ----
  // write-once shadow flags
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done1_reg;
  logic done2_reg;
  wire logic wr = psel && penable && pwrite && pready && clk_en;
  wire logic wr1 = wr && paddr == latch_one_addr;
  wire logic wr2 = wr && paddr == latch_two_addr;
  wire logic new1 = wr1 && !done1_reg && pstrb[0];
  // any write consumes the flag, strobe or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done1_reg <= 1'b0;
      done2_reg <= 1'b0;
    end else begin
      done1_reg <= done1_reg | wr1;
      done2_reg <= done2_reg | wr2;
    end
  end
  property p_once; (wr1 && done1_reg) || (wr2 && done2_reg) |=> $stable(settings); endproperty
  a_once: assert property (p_once) else $error("late write changed settings");
  property p_rate; new1 |=> settings.watchdog_timeout == ($past(pwdata[7]) ? 18'h01ff0 : 18'h3fff0); endproperty
  a_rate: assert property (p_rate) else $error("watchdog timeout wrong");
  property p_wdog; new1 |=> settings.watchdog_enable == !$past(pwdata[0]); endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");
  property p_short; new1 ##1 !stop_exit_by_reset |-> stop_recovery_cycles == ($past(pwdata[2]) ? 13'h0020 : 13'h1000); endproperty
  a_short: assert property (p_short) else $error("recovery count wrong");
  property p_rexit; stop_exit_by_reset |-> stop_recovery_cycles == 13'h1000; endproperty
  a_rexit: assert property (p_rexit) else $error("reset exit not long");
  property p_clear; !done1_reg |-> settings.watchdog_timeout == 18'h3fff0 && settings.watchdog_enable && !settings.stop_allowed; endproperty
  a_clear: assert property (p_clear) else $error("unwritten latch not clear");
  property p_mon; settings.monitor_active_in_stop |-> settings.supply_monitor_on || settings.regulator_monitor_on; endproperty
  a_mon: assert property (p_mon) else $error("monitor active with circuits off");
  property p_tbase; wr2 && !done2_reg && pstrb[0] |=> settings.timebase_src == $past(pwdata[4:3]); endproperty
  a_tbase: assert property (p_tbase) else $error("timebase source wrong");
  property p_err; psel && penable && paddr != latch_one_addr && paddr != latch_two_addr |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  c_late: cover property (wr1 && done1_reg);
  c_rexit: cover property (stop_exit_by_reset);
  c_err: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// [dv/tb_write_once_option_latches.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_write_once_option_latches
  import option_latch_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stop_exit_by_reset = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [12:0] stop_recovery_cycles;
  logic [7:0] v1, v2;
  logic [1:0] k;
  option_settings_t settings;
  int fails = 0;
  int n_checks = 0;
  write_once_option_latches u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_exit_by_reset(stop_exit_by_reset),
    .settings(settings), .stop_recovery_cycles(stop_recovery_cycles));
  initial begin
    forever #10 pclk = ~pclk;
  end
  // ----
  // bus and check helpers
  // ----
  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; an idle edge after it avoids re-driving psel in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  initial begin
    @(posedge pclk);
    do_reset();
    xfer(1'b0, latch_one_addr, 32'h0);
    chk("latch one", 32'h0, rd);
    chk("mapped err", 32'h0, {31'h0, er});
    xfer(1'b0, 8'h78, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    // frozen write is lost; strobe-less write still uses up the one write
    clk_en <= 1'b0;
    xfer(1'b1, latch_two_addr, 32'h3f);
    clk_en <= 1'b1;
    pstrb <= 4'h0;
    xfer(1'b1, latch_two_addr, 32'h3f);
    pstrb <= 4'hf;
    xfer(1'b1, latch_two_addr, 32'hff);
    xfer(1'b0, latch_two_addr, 32'h0);
    chk("latch two", 32'h0, rd);
    xfer(1'b1, latch_one_addr, 32'hffffff86);
    xfer(1'b1, latch_one_addr, 32'h79);
    xfer(1'b0, latch_one_addr, 32'h0);
    chk("latch one", 32'h86, rd);
    chk("timeout", 32'h1ff0, 32'(settings.watchdog_timeout));
    chk("stop allowed", 32'h1, {31'h0, settings.stop_allowed});
    chk("recovery", 32'h20, 32'(stop_recovery_cycles));
    stop_exit_by_reset <= 1'b1;
    @(posedge pclk);
    chk("reset recovery", 32'h1000, 32'(stop_recovery_cycles));
    stop_exit_by_reset <= 1'b0;
    // every timebase code, with monitor and oscillator mixes
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      v1 = {k[1], 1'b1, k[0], k[1], k[1] ^ k[0], 2'b00, k[0]};
      v2 = {k[0], k[1], ~k[0], k, 2'b10, k[1]};
      do_reset();
      xfer(1'b1, latch_one_addr, {24'h0, v1});
      xfer(1'b1, latch_two_addr, {24'h0, v2});
      xfer(1'b0, latch_two_addr, 32'h0);
      chk("latch two", {24'h0, v2}, rd);
      chk("timebase", 32'(k), 32'(settings.timebase_src));
      chk("serial clk", 32'(v2[0]), 32'(settings.serial_port_from_bus));
      chk("osc stop", {29'h0, ~v2[7], v2[6], v2[5]}, {29'h0, settings.internal_osc_run_in_stop,
        settings.rc_osc_run_in_stop, settings.crystal_osc_run_in_stop});
      chk("monitors", {27'h0, v1[6] & ~(v1[4] & v1[3]), ~v1[5], ~v1[4], ~v1[3], ~v1[0]},
        {27'h0, settings.monitor_active_in_stop, settings.monitor_reset_enable,
        settings.supply_monitor_on, settings.regulator_monitor_on,
        settings.watchdog_enable});
    end
    give_verdict();
  end
endmodule
bind write_once_option_latches write_once_option_latches_chk u_chk (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .stop_exit_by_reset(stop_exit_by_reset), .settings(settings),
  .stop_recovery_cycles(stop_recovery_cycles));
`default_nettype wire
